// File: dcf_bus_model.sv
// Partner model of the internal bus controller: grants on request and ends each access after a set wait.
`timescale 1ns/1ps
module dcf_bus_model (
	input logic aclk,
	input logic aresetn,
	input logic bus_req,
	input logic bus_cyc,
	input logic [31:0] bus_addr,
	input logic [1:0] lat,
	output logic bus_grant,
	output logic [31:0] bus_rdata,
	output logic bus_done
);
	logic [1:0] wait_r;
	// Read data is only good with the done pulse; it flips every cycle so stale use shows.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_grant <= 1'b0;
			bus_done <= 1'b0;
			wait_r <= 2'h0;
			bus_rdata <= 32'h0;
		end else begin
			bus_grant <= bus_req;
			bus_done <= 1'b0;
			bus_rdata <= ~bus_rdata;
			if (bus_cyc && !bus_done) begin
				wait_r <= wait_r + 2'h1;
				if (wait_r == lat) begin
					bus_done <= 1'b1;
					wait_r <= 2'h0;
					bus_rdata <= bus_addr ^ 32'hc3c3_0000;
				end
			end
		end
	end
endmodule

// File: dcf_channel.sv
// One DMA channel: control register decoding, transfer sequencing and its AXI4-Lite register slave.
`timescale 1ns/1ps
module dcf_channel
	import dcf_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic bus_req,
	input wire logic bus_grant,
	output logic bus_cyc,
	output logic [31:0] bus_addr,
	output logic bus_read,
	output logic [1:0] bus_width,
	output logic [31:0] bus_wdata,
	input wire logic [31:0] bus_rdata,
	input wire logic bus_done,
	input wire logic ext_request_in,
	output logic dma_ack,
	output logic irq
);
	import dcf_pkg::*;

	// Whole module state; the bus-facing outputs are fields so they come straight from flops.
	typedef struct packed {
		dcf_state_t state;
		logic [2:0] bandwidth_block_size;
		logic single_addr_select;
		logic dir_read;
		logic src_addr_step_en;
		logic [1:0] src_width;
		logic dst_addr_step_en;
		logic [1:0] dst_width;
		logic ack_type;
		logic ext_request_enable;
		logic start;
		logic wide_count_select;
		logic [31:0] source_address_reg;
		logic [31:0] dest_address_reg;
		logic [23:0] byte_count;
		logic [1:0] status;
		logic [1:0] mask;
		logic ext_run;
		logic aw_held;
		logic [4:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic req;
		logic cyc;
		logic [31:0] addr;
		logic rd;
		logic [1:0] width;
		logic [31:0] data;
		logic ack;
		logic irq;
	} dcf_regs_t;

	dcf_regs_t q_r;
	dcf_regs_t q_nxt;

	// Bytes moved by one access of the given width.
	function automatic logic [4:0] dcf_width_bytes(input logic [1:0] w);
		case (w)
			DCF_W_BYTE: dcf_width_bytes = 5'h01;
			DCF_W_WORD: dcf_width_bytes = 5'h02;
			DCF_W_LINE: dcf_width_bytes = 5'h10;
			default: dcf_width_bytes = 5'h04;
		endcase
	endfunction

	// Byte-lane merge for partial AXI writes.
	function automatic logic [31:0] dcf_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[8*i +: 8] = nw[8*i +: 8];
			end
		end
		dcf_merge = m;
	endfunction

	// Control word as software sees it; start always reads zero, ack type only with the wide counter.
	function automatic logic [31:0] dcf_ctrl_word(input dcf_regs_t s);
		logic [31:0] c;
		c = DCF_RST_WORD;
		c[DCF_EXT_REQUEST_ENABLE_BIT] = s.ext_request_enable;
		c[DCF_BWC_LSB +: 3] = s.bandwidth_block_size;
		c[DCF_SAA_BIT] = s.single_addr_select;
		c[DCF_SRW_BIT] = s.dir_read;
		c[DCF_SRC_ADDR_STEP_EN_BIT] = s.src_addr_step_en;
		c[DCF_SRC_WIDTH_LSB +: 2] = s.src_width;
		c[DCF_DST_ADDR_STEP_EN_BIT] = s.dst_addr_step_en;
		c[DCF_DST_WIDTH_LSB +: 2] = s.dst_width;
		c[DCF_AT_BIT] = s.ack_type & s.wide_count_select;
		dcf_ctrl_word = c;
	endfunction

	logic [23:0] cnt_eff;
	logic [4:0] src_bytes;
	logic [4:0] dst_bytes;
	logic [4:0] xfer_bytes;
	logic [23:0] cnt_left;
	logic [23:0] blk_mask;
	logic misaligned;
	logic kick;
	logic wr_fire;
	logic wr_hit;
	logic [31:0] wr_val;
	logic [1:0] st_set;

	// Transfer size and block boundary arithmetic shared by the start check and the step.
	always_comb begin
		cnt_eff = q_r.wide_count_select ? q_r.byte_count : {8'h00, q_r.byte_count[15:0]};
		src_bytes = dcf_width_bytes(q_r.src_width);
		dst_bytes = dcf_width_bytes(q_r.dst_width);
		// Single-address mode has only the source access, so its width alone counts.
		if (q_r.single_addr_select || src_bytes >= dst_bytes) begin
			xfer_bytes = src_bytes;
		end else begin
			xfer_bytes = dst_bytes;
		end
		misaligned = (cnt_eff[3:0] & (xfer_bytes[3:0] - 4'h1)) != 4'h0;
		if (xfer_bytes == 5'h10) begin
			misaligned = cnt_eff[3:0] != 4'h0;
		end
		cnt_left = cnt_eff - {19'h0, xfer_bytes};
		blk_mask = (24'h00_0001 << ((q_r.wide_count_select ? DCF_BLK_SHIFT_WIDE : DCF_BLK_SHIFT_NARROW)
			+ {2'h0, q_r.bandwidth_block_size})) - 24'h00_0001;
		kick = q_r.start || (q_r.ext_request_enable && ext_request_in);
	end

	// Register writes, the channel sequencer and the AXI handshakes in one next-state process.
	always_comb begin
		q_nxt = q_r;
		st_set = 2'h0;
		q_nxt.start = 1'b0;
		wr_fire = q_r.aw_held && q_r.w_held && !q_r.bvalid;
		wr_hit = 1'b1;
		wr_val = q_r.w_data;

		// Address and data are taken independently and held until the write is performed.
		if (s_axi_awvalid && !q_r.aw_held) begin
			q_nxt.aw_held = 1'b1;
			q_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q_r.w_held) begin
			q_nxt.w_held = 1'b1;
			q_nxt.w_data = s_axi_wdata;
			q_nxt.w_strb = s_axi_wstrb;
		end
		if (q_r.bvalid && s_axi_bready) begin
			q_nxt.bvalid = 1'b0;
		end

		// Register write; writes to the map while a transfer runs still land, software must not do so.
		if (wr_fire) begin
			q_nxt.aw_held = 1'b0;
			q_nxt.w_held = 1'b0;
			q_nxt.bvalid = 1'b1;
			case (q_r.aw_addr)
				DCF_OFS_CTRL: begin
					wr_val = dcf_merge(dcf_ctrl_word(q_r), q_r.w_data, q_r.w_strb);
					q_nxt.ext_request_enable = wr_val[DCF_EXT_REQUEST_ENABLE_BIT];
					q_nxt.bandwidth_block_size = wr_val[DCF_BWC_LSB +: 3];
					q_nxt.single_addr_select = wr_val[DCF_SAA_BIT];
					q_nxt.dir_read = wr_val[DCF_SRW_BIT];
					q_nxt.src_addr_step_en = wr_val[DCF_SRC_ADDR_STEP_EN_BIT];
					q_nxt.src_width = wr_val[DCF_SRC_WIDTH_LSB +: 2];
					q_nxt.dst_addr_step_en = wr_val[DCF_DST_ADDR_STEP_EN_BIT];
					q_nxt.dst_width = wr_val[DCF_DST_WIDTH_LSB +: 2];
					q_nxt.ack_type = wr_val[DCF_AT_BIT] & q_r.wide_count_select;
					q_nxt.start = wr_val[DCF_START_BIT] && q_r.w_strb[2];
				end
				DCF_OFS_SRC: q_nxt.source_address_reg = dcf_merge(q_r.source_address_reg, q_r.w_data, q_r.w_strb);
				DCF_OFS_DST: q_nxt.dest_address_reg = dcf_merge(q_r.dest_address_reg, q_r.w_data, q_r.w_strb);
				DCF_OFS_CNT: begin
					wr_val = dcf_merge({8'h00, q_r.byte_count}, q_r.w_data, q_r.w_strb);
					q_nxt.byte_count = wr_val[23:0];
				end
				DCF_OFS_STAT: begin
					// Clear by writing one; a new event in the same cycle is merged in below.
					q_nxt.status = q_r.status & ~(q_r.w_data[1:0] & {2{q_r.w_strb[0]}});
				end
				DCF_OFS_MASK: begin
					if (q_r.w_strb[0]) begin
						q_nxt.mask = q_r.w_data[1:0];
					end
				end
				DCF_OFS_CFG: begin
					if (q_r.w_strb[0]) begin
						q_nxt.wide_count_select = q_r.w_data[0];
						q_nxt.ack_type = q_nxt.ack_type & q_r.w_data[0];
					end
				end
				default: wr_hit = 1'b0;
			endcase
			q_nxt.bresp = wr_hit ? DCF_RESP_OKAY : DCF_RESP_SLVERR;
		end

		// Channel sequencer.
		case (q_r.state)
			DCF_IDLE: begin
				if (kick) begin
					if (cnt_eff == 24'h00_0000 || misaligned) begin
						st_set[DCF_ST_CE_BIT] = 1'b1;
					end else begin
						q_nxt.ext_run = !q_r.start;
						q_nxt.state = DCF_ARB;
					end
				end
			end
			DCF_ARB: begin
				q_nxt.req = 1'b1;
				if (bus_grant && q_r.req) begin
					q_nxt.cyc = 1'b1;
					q_nxt.addr = q_r.source_address_reg;
					q_nxt.width = q_r.src_width;
					// Dual mode always reads the source; single mode forces the direction bit.
					q_nxt.rd = q_r.single_addr_select ? q_r.dir_read : 1'b1;
					q_nxt.state = DCF_RD;
				end
			end
			DCF_RD: begin
				if (bus_done) begin
					q_nxt.cyc = 1'b0;
					q_nxt.data = bus_rdata;
					q_nxt.state = DCF_STEP;
					if (!q_r.single_addr_select) begin
						q_nxt.cyc = 1'b1;
						q_nxt.addr = q_r.dest_address_reg;
						q_nxt.width = q_r.dst_width;
						q_nxt.rd = 1'b0;
						q_nxt.state = DCF_WR;
					end
				end
			end
			DCF_WR: begin
				if (bus_done) begin
					q_nxt.cyc = 1'b0;
					q_nxt.state = DCF_STEP;
				end
			end
			DCF_STEP: begin
				if (q_r.src_addr_step_en) begin
					q_nxt.source_address_reg = q_r.source_address_reg + {27'h0, src_bytes};
				end
				if (q_r.dst_addr_step_en && !q_r.single_addr_select) begin
					q_nxt.dest_address_reg = q_r.dest_address_reg + {27'h0, dst_bytes};
				end
				q_nxt.byte_count = cnt_left;
				q_nxt.state = DCF_ARB;
				if (cnt_left == 24'h00_0000) begin
					q_nxt.req = 1'b0;
					q_nxt.ext_run = 1'b0;
					q_nxt.state = DCF_IDLE;
					st_set[DCF_ST_DONE_BIT] = 1'b1;
				end else if (q_r.bandwidth_block_size != 3'h0 && (cnt_left & blk_mask) == 24'h00_0000) begin
					// Dropping the request for one cycle lets other masters win arbitration.
					q_nxt.req = 1'b0;
				end
			end
			default: begin
				q_nxt.state = DCF_IDLE;
				q_nxt.req = 1'b0;
				q_nxt.cyc = 1'b0;
			end
		endcase
		q_nxt.status = q_nxt.status | st_set;

		// Acknowledge follows the cycle strobe of externally requested runs only; with the final-only type it waits for the last transfer.
		q_nxt.ack = q_nxt.cyc && q_nxt.ext_run
			&& (!(q_r.ack_type && q_r.wide_count_select) || cnt_eff == {19'h0, xfer_bytes});

		// Register read; answers one cycle after the address is taken.
		if (q_r.rvalid && s_axi_rready) begin
			q_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q_r.rvalid) begin
			q_nxt.rvalid = 1'b1;
			q_nxt.rresp = DCF_RESP_OKAY;
			case (s_axi_araddr)
				DCF_OFS_CTRL: q_nxt.rdata = dcf_ctrl_word(q_r);
				DCF_OFS_SRC: q_nxt.rdata = q_r.source_address_reg;
				DCF_OFS_DST: q_nxt.rdata = q_r.dest_address_reg;
				DCF_OFS_CNT: q_nxt.rdata = {8'h00, cnt_eff};
				DCF_OFS_STAT: q_nxt.rdata = {23'h0, q_r.state != DCF_IDLE, 6'h00, q_r.status};
				DCF_OFS_MASK: q_nxt.rdata = {30'h0, q_r.mask};
				DCF_OFS_CFG: q_nxt.rdata = {31'h0, q_r.wide_count_select};
				default: begin
					q_nxt.rdata = DCF_RST_WORD;
					q_nxt.rresp = DCF_RESP_SLVERR;
				end
			endcase
		end

		q_nxt.irq = |(q_nxt.status & q_nxt.mask);
	end

	// State register with synchronous reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_r <= '0;
			q_r.state <= DCF_IDLE;
			q_r.byte_count <= DCF_RST_CNT;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Ports come directly from the state flops.
	assign s_axi_awready = !q_r.aw_held;
	assign s_axi_wready = !q_r.w_held;
	assign s_axi_bvalid = q_r.bvalid;
	assign s_axi_bresp = q_r.bresp;
	assign s_axi_arready = !q_r.rvalid;
	assign s_axi_rvalid = q_r.rvalid;
	assign s_axi_rdata = q_r.rdata;
	assign s_axi_rresp = q_r.rresp;
	assign bus_req = q_r.req;
	assign bus_cyc = q_r.cyc;
	assign bus_addr = q_r.addr;
	assign bus_read = q_r.rd;
	assign bus_width = q_r.width;
	assign bus_wdata = q_r.data;
	assign dma_ack = q_r.ack;
	assign irq = q_r.irq;
endmodule

// File: dcf_chk.sv
// Checker holding the port-level assertions of the DMA channel, and its bind.
`timescale 1ns/1ps
module dcf_chk (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic bus_req,
	input logic bus_grant,
	input logic bus_cyc,
	input logic [31:0] bus_addr,
	input logic bus_read,
	input logic [1:0] bus_width,
	input logic bus_done,
	input logic dma_ack
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// An access in flight, a read that just ended, and a won arbitration not yet used.
	sequence s_pending;
		bus_cyc && !bus_done;
	endsequence
	sequence s_read_done;
		bus_cyc && bus_read && bus_done;
	endsequence
	sequence s_won;
		bus_req && bus_grant && !bus_cyc;
	endsequence
	a_access_holds: assert property (s_pending |=> bus_cyc && $stable(bus_addr) && $stable(bus_width))
		else $error("Access changed before it was ended.");
	a_cyc_under_req: assert property (bus_cyc |-> bus_req)
		else $error("Access without bus request.");
	a_ack_in_access: assert property (dma_ack |-> bus_cyc)
		else $error("Acknowledge outside an access.");
	a_grant_starts: assert property (s_won |-> ##[1:2] (bus_cyc || !bus_req))
		else $error("Grant did not start an access.");
	a_cyc_after_grant: assert property ($rose(bus_cyc) |-> $past(bus_grant))
		else $error("Access began without a grant.");
	a_no_read_pair: assert property (s_read_done |=> !bus_cyc || !bus_read)
		else $error("Read followed directly by another read.");
	a_rvalid_clears: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("Read response repeated.");
	a_ar_gated: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read address accepted with a response pending.");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("Read response dropped before it was taken.");
endmodule
bind dcf_channel dcf_chk i_dcf_chk (.*);

// File: dcf_pkg.sv
// Package with register map, field positions, reset values and state codes for the DMA channel.
package dcf_pkg;
	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [4:0] DCF_OFS_CTRL = 5'h00;
	localparam logic [4:0] DCF_OFS_SRC = 5'h04;
	localparam logic [4:0] DCF_OFS_DST = 5'h08;
	localparam logic [4:0] DCF_OFS_CNT = 5'h0c;
	localparam logic [4:0] DCF_OFS_STAT = 5'h10;
	localparam logic [4:0] DCF_OFS_MASK = 5'h14;
	localparam logic [4:0] DCF_OFS_CFG = 5'h18;
	// Control register field positions.
	localparam int DCF_BWC_LSB = 25;
	localparam int DCF_SAA_BIT = 24;
	localparam int DCF_SRW_BIT = 23;
	localparam int DCF_SRC_ADDR_STEP_EN_BIT = 22;
	localparam int DCF_SRC_WIDTH_LSB = 20;
	localparam int DCF_DST_ADDR_STEP_EN_BIT = 19;
	localparam int DCF_DST_WIDTH_LSB = 17;
	localparam int DCF_START_BIT = 16;
	localparam int DCF_AT_BIT = 15;
	localparam int DCF_EXT_REQUEST_ENABLE_BIT = 30;
	// Status register field positions, interrupt bits first.
	localparam int DCF_ST_DONE_BIT = 0;
	localparam int DCF_ST_CE_BIT = 1;
	localparam int DCF_ST_BUSY_BIT = 8;
	// Transfer width codes.
	localparam logic [1:0] DCF_W_LONG = 2'h0;
	localparam logic [1:0] DCF_W_BYTE = 2'h1;
	localparam logic [1:0] DCF_W_WORD = 2'h2;
	localparam logic [1:0] DCF_W_LINE = 2'h3;
	// Block size shifts: code 1 selects 512 or 16384 bytes, each further code doubles.
	localparam logic [4:0] DCF_BLK_SHIFT_NARROW = 5'h08;
	localparam logic [4:0] DCF_BLK_SHIFT_WIDE = 5'h0d;
	// Reset values.
	localparam logic [31:0] DCF_RST_WORD = 32'h0000_0000;
	localparam logic [23:0] DCF_RST_CNT = 24'h00_0000;
	// AXI responses.
	localparam logic [1:0] DCF_RESP_OKAY = 2'h0;
	localparam logic [1:0] DCF_RESP_SLVERR = 2'h2;
	// Channel states, one-hot.
	typedef enum logic [4:0] {
		DCF_IDLE = 5'b00001,
		DCF_ARB = 5'b00010,
		DCF_RD = 5'b00100,
		DCF_WR = 5'b01000,
		DCF_STEP = 5'b10000
	} dcf_state_t;
endpackage

// File: tb.sv
// Testbench for the DMA channel: register tasks, transfer runs and bus log checks.
`timescale 1ns/1ps
module tb;
	import dcf_pkg::*;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, ext_request_in = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, bus_req, bus_grant, bus_cyc, bus_read, bus_done, dma_ack, irq;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, bus_addr, bus_wdata, bus_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, bus_width, rsp, lat = 0;
	int err_total = 0, samples_checked = 0, acks = 0, falls = 0, sz, inc;
	logic [31:0] addr_q[$], data_q[$];
	logic read_q[$];
	logic [1:0] width_q[$];
	dcf_channel i_dcf_channel (.*);
	dcf_bus_model i_dcf_bus_model (.*);
	always #2 aclk = ~aclk;
	// Every completed access is logged so whole transfers are judged after they end.
	always @(posedge aclk) begin
		if (aresetn && bus_cyc && bus_done) begin
			addr_q.push_back(bus_addr);
			read_q.push_back(bus_read);
			width_q.push_back(bus_width);
			data_q.push_back(bus_wdata);
			acks += dma_ack;
		end
	end
	always @(negedge bus_req) falls++;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bit ad = 0;
		bit wd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			ad |= s_axi_awready;
			wd |= s_axi_wready;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !wd;
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rdr(input logic [4:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// One transfer from fixed addresses; polling stops once done or config error shows.
	task automatic run(input logic [31:0] cnt, input logic [31:0] ctrl, input bit ext);
		int n = 0;
		addr_q.delete();
		read_q.delete();
		width_q.delete();
		data_q.delete();
		acks = 0;
		wr(DCF_OFS_SRC, 32'h100);
		wr(DCF_OFS_DST, 32'h2000);
		wr(DCF_OFS_CNT, cnt);
		falls = 0;
		wr(DCF_OFS_CTRL, ctrl);
		if (ext) begin
			ext_request_in <= 1;
			do @(posedge aclk); while (!bus_req);
			ext_request_in <= 0;
		end
		do begin
			rdr(DCF_OFS_STAT);
			n++;
		end while (rd[1:0] === 2'h0 && n < 400);
	endtask
	task automatic results;
		if (err_total == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// The watchdog allows several times the expected run length.
	initial begin
		#200000;
		err_total++;
		results();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		rdr(DCF_OFS_CTRL);
		chk(rd, DCF_RST_WORD);
		rdr(5'h1c);
		chk({30'h0, rsp}, {30'h0, DCF_RESP_SLVERR});
		wr(5'h1c, 32'h1);
		chk({30'h0, rsp}, {30'h0, DCF_RESP_SLVERR});
		wr(DCF_OFS_CTRL, 32'h0000_8000);
		rdr(DCF_OFS_CTRL);
		chk(rd, 32'h0);
		wr(DCF_OFS_CFG, 32'h1);
		wr(DCF_OFS_CTRL, 32'h0000_8000);
		rdr(DCF_OFS_CTRL);
		chk(rd, 32'h0000_8000);
		wr(DCF_OFS_CTRL, 32'h0);
		wr(DCF_OFS_CFG, 32'h0);
		wr(DCF_OFS_MASK, 32'h0);
		run(6, 32'h0001_0000, 0);
		chk(rd, 32'h2);
		chk(32'(addr_q.size()), 0);
		@(negedge aclk);
		chk({31'h0, irq}, 0);
		wr(DCF_OFS_MASK, 32'h2);
		@(negedge aclk);
		chk({31'h0, irq}, 1);
		wr(DCF_OFS_STAT, 32'h2);
		@(negedge aclk);
		chk({31'h0, irq}, 0);
		// Each width in dual mode, with the longword case run without address steps.
		for (int w = 0; w < 4; w++) begin
			sz = (w == 0) ? 4 : (w == 1) ? 1 : (w == 2) ? 2 : 16;
			inc = (w != 0);
			lat <= w[1:0];
			// The direction bit is set with the steps; dual mode must ignore it.
			run(2 * sz, {7'h0, 1'b0, inc[0], inc[0], w[1:0], inc[0], w[1:0], 1'b1, 16'h0}, 0);
			chk(rd, 32'h1);
			chk(32'(addr_q.size()), 4);
			for (int k = 0; k < 4; k++) begin
				chk(addr_q[k], (k[0] ? 32'h2000 : 32'h100) + (k / 2) * sz * inc);
				chk({31'h0, read_q[k]}, {31'h0, !k[0]});
				chk({30'h0, width_q[k]}, {30'h0, w[1:0]});
			end
			chk(data_q[3], (32'h100 + sz * inc) ^ 32'hc3c3_0000);
			chk(acks, 0);
			rdr(DCF_OFS_SRC);
			chk(rd, 32'h100 + 2 * sz * inc);
			rdr(DCF_OFS_CTRL);
			chk(rd, {7'h0, 1'b0, inc[0], inc[0], w[1:0], inc[0], w[1:0], 1'b0, 16'h0});
			wr(DCF_OFS_STAT, 32'h1);
		end
		for (int d = 0; d < 2; d++) begin
			run(2, {7'h0, 1'b1, d[0], 1'b1, DCF_W_BYTE, 1'b0, DCF_W_BYTE, 1'b1, 16'h0}, 0);
			chk(32'(addr_q.size()), 2);
			for (int k = 0; k < 2; k++) begin
				chk(addr_q[k], 32'h100 + k);
				chk({31'h0, read_q[k]}, d);
			end
			wr(DCF_OFS_STAT, 32'h1);
		end
		for (int b = 0; b < 3; b++) begin
			run(32'h400, {4'h0, b[2:0], 3'h1, DCF_W_LINE, 1'b1, DCF_W_LINE, 1'b1, 16'h0}, 0);
			chk(falls, (b == 1) ? 2 : 1);
			chk(32'(addr_q.size()), 128);
			wr(DCF_OFS_STAT, 32'h1);
		end
		wr(DCF_OFS_CFG, 32'h1);
		for (int t = 0; t < 2; t++) begin
			run(4, {2'h1, 5'h0, 3'h1, DCF_W_BYTE, 1'b1, DCF_W_BYTE, 1'b0, t[0], 15'h0}, 1);
			chk(acks, t ? 2 : 8);
			wr(DCF_OFS_STAT, 32'h1);
		end
		results();
	end
endmodule
